/* hdl/mcc_pkg.sv */
// Package: constants and types for the channel two protection configuration bank
package mcc_pkg;

	// ==========================================================
	// Register map
	localparam logic [6:0]  CH2_CFG_ADDR     = 7'h05;
	localparam int          DATA_W           = 32;
	localparam logic [31:0] CH2_CFG_RESET    = 32'h0000_0000;
	localparam logic [31:0] CH2_CFG_WMASK    = 32'h0077_f800;

	// ==========================================================
	// Field positions
	localparam int OL_IDLE_LSB   = 21;
	localparam int REGEN_BIT     = 20;
	localparam int ILIM_HI_BIT   = 18;
	localparam int ILIM_HYS_BIT  = 17;
	localparam int OL_RUN_LSB    = 15;
	localparam int SLEW_LSB      = 12;
	localparam int OC_MODE_BIT   = 11;

	// ==========================================================
	// Open-load idle detection times, in microseconds and in 125 MHz clock cycles
	localparam int OL_IDLE_100_US = 100;
	localparam int OL_IDLE_50_US  = 50;
	localparam int OL_IDLE_500_US = 500;
	localparam int CLK_MHZ        = 125;
	localparam int OL_IDLE_100_CYC = OL_IDLE_100_US * CLK_MHZ;
	localparam int OL_IDLE_50_CYC  = OL_IDLE_50_US * CLK_MHZ;
	localparam int OL_IDLE_500_CYC = OL_IDLE_500_US * CLK_MHZ;
	localparam int CNT_W           = 17;

	// ==========================================================
	// Codes
	localparam logic [1:0] OL_IDLE_100 = 2'h0;
	localparam logic [1:0] OL_IDLE_50  = 2'h1;
	localparam logic [1:0] OL_IDLE_500 = 2'h2;
	localparam logic [1:0] OL_IDLE_UND = 2'h3;
	localparam logic [1:0] OL_RUN_200  = 2'h0;
	localparam logic [1:0] OL_RUN_100  = 2'h1;
	localparam logic [1:0] OL_RUN_300  = 2'h2;

	typedef enum logic [2:0] {
		MCC_SLEW_OFF,
		MCC_SLEW_SLOW1,
		MCC_SLEW_SLOW2,
		MCC_SLEW_SLOW3,
		MCC_SLEW_SLOW4,
		MCC_SLEW_FAST2,
		MCC_SLEW_FAST1
	} mcc_slew_t;

	typedef enum logic [1:0] {
		MCC_OLR_100MA,
		MCC_OLR_200MA,
		MCC_OLR_300MA
	} mcc_olrun_t;

	// Decoded settings handed to the analogue side
	typedef struct packed {
		logic [1:0]  ol_idle_code;
		logic [16:0] ol_idle_cycles;
		logic        ol_idle_valid;
		logic        regen_high_side;
		logic        ilim_upper_low;
		logic        ilim_hys_wide;
		mcc_olrun_t  ol_run_thresh;
		mcc_slew_t   slew_mode;
		logic        oc_auto_recover;
	} mcc_cfg_t;

	// Register write/read request from the SPI register port
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [6:0]  addr;
		logic [31:0] wdata;
	} mcc_req_t;

endpackage

/* hdl/mcc_decode.sv */
// Decoder from raw register bits to settings for channel two
`timescale 1ns/10ps
module mcc_decode
(
	// Raw register contents
	input  wire logic [31:0]      reg_bits,
	// Decoded settings
	output mcc_pkg::mcc_cfg_t     cfg
);
	// ==========================================================
	// Field extraction
	wire logic [1:0] ol_idle_w = reg_bits[mcc_pkg::OL_IDLE_LSB +: 2];
	wire logic [1:0] ol_run_w  = reg_bits[mcc_pkg::OL_RUN_LSB +: 2];
	wire logic [2:0] slew_w    = reg_bits[mcc_pkg::SLEW_LSB +: 3];

	// Undefined idle code is flagged invalid; time held at default
	wire logic [16:0] idle_cyc_w =
		(ol_idle_w == mcc_pkg::OL_IDLE_50)  ? 17'(mcc_pkg::OL_IDLE_50_CYC)  :
		(ol_idle_w == mcc_pkg::OL_IDLE_500) ? 17'(mcc_pkg::OL_IDLE_500_CYC) :
		17'(mcc_pkg::OL_IDLE_100_CYC);

	wire mcc_pkg::mcc_olrun_t olrun_w =
		(ol_run_w == mcc_pkg::OL_RUN_100) ? mcc_pkg::MCC_OLR_100MA :
		(ol_run_w == mcc_pkg::OL_RUN_300) ? mcc_pkg::MCC_OLR_300MA :
		mcc_pkg::MCC_OLR_200MA;

	// 101 is the second fastest, 110 the fastest; 111 aliases off
	wire mcc_pkg::mcc_slew_t slew_mode_w =
		(slew_w == 3'h7) ? mcc_pkg::MCC_SLEW_OFF : mcc_pkg::mcc_slew_t'(slew_w);

	assign cfg.ol_idle_code    = ol_idle_w;
	assign cfg.ol_idle_cycles  = idle_cyc_w;
	assign cfg.ol_idle_valid   = (ol_idle_w != mcc_pkg::OL_IDLE_UND);
	assign cfg.regen_high_side = reg_bits[mcc_pkg::REGEN_BIT];
	assign cfg.ilim_upper_low  = reg_bits[mcc_pkg::ILIM_HI_BIT];
	assign cfg.ilim_hys_wide   = reg_bits[mcc_pkg::ILIM_HYS_BIT];
	assign cfg.ol_run_thresh   = olrun_w;
	assign cfg.slew_mode       = slew_mode_w;
	assign cfg.oc_auto_recover = reg_bits[mcc_pkg::OC_MODE_BIT];

endmodule

/* hdl/mcc_cfg_bank.sv */
// Channel two protection configuration register and its decoded settings
`timescale 1ns/10ps
module mcc_cfg_bank
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Register port from the SPI frame decoder
	input  mcc_pkg::mcc_req_t     req,
	output logic [31:0]           rdata_r,
	output logic                  rvalid_r,
	// Settings to the channel two bridge
	output mcc_pkg::mcc_cfg_t     cfg_r
);
	// ==========================================================
	// Register storage
	logic [31:0]       cfg_reg_r;
	logic [31:0]       cfg_reg_nxt;
	mcc_pkg::mcc_cfg_t cfg_dec;

	wire logic hit_w = (req.addr == mcc_pkg::CH2_CFG_ADDR);
	wire logic wr_w  = req.wr && hit_w;
	wire logic rd_w  = req.rd && hit_w;

	// Masking keeps unassigned positions at zero on every write
	assign cfg_reg_nxt = wr_w ? (req.wdata & mcc_pkg::CH2_CFG_WMASK) : cfg_reg_r;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cfg_reg_r <= mcc_pkg::CH2_CFG_RESET;
		else
			cfg_reg_r <= cfg_reg_nxt;
	end

	// ==========================================================
	// Read path; unmapped addresses answer zero
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdata_r  <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r  <= rd_w ? (cfg_reg_r & mcc_pkg::CH2_CFG_WMASK) : 32'h0000_0000;
			rvalid_r <= req.rd;
		end
	end

	// ==========================================================
	// Decode and register the settings
	mcc_decode u_decode
	(
		.reg_bits (cfg_reg_r),
		.cfg      (cfg_dec)
	);

	// Outputs lag the register by one cycle so they come from flops
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cfg_r <= '{ol_idle_code: 2'h0, ol_idle_cycles: 17'(mcc_pkg::OL_IDLE_100_CYC),
				ol_idle_valid: 1'b1, ol_run_thresh: mcc_pkg::MCC_OLR_200MA,
				slew_mode: mcc_pkg::MCC_SLEW_OFF, default: 1'b0};
		else
			cfg_r <= cfg_dec;
	end

	// ==========================================================
	// Checks
	// Field views keep bit positions out of the properties
	wire logic [1:0] idle_fld_w = cfg_reg_r[mcc_pkg::OL_IDLE_LSB +: 2];
	wire logic [1:0] run_fld_w  = cfg_reg_r[mcc_pkg::OL_RUN_LSB +: 2];
	wire logic [2:0] slew_fld_w = cfg_reg_r[mcc_pkg::SLEW_LSB +: 3];
	wire logic [1:0] idle_wr_w  = req.wdata[mcc_pkg::OL_IDLE_LSB +: 2];

	a_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
		(cfg_reg_r & ~mcc_pkg::CH2_CFG_WMASK) == 32'h0000_0000)
		else $error("reserved bits not zero");

	a_write_takes: assert property (@(posedge clk) disable iff (!reset_n)
		wr_w |=> idle_fld_w == $past(idle_wr_w))
		else $error("idle time field not written");

	a_regen_out: assert property (@(posedge clk) disable iff (!reset_n)
		wr_w |=> ##1 cfg_r.regen_high_side == $past(req.wdata[mcc_pkg::REGEN_BIT], 2))
		else $error("regeneration side wrong");

	a_ilim_upper: assert property (@(posedge clk) disable iff (!reset_n)
		wr_w |=> ##1 cfg_r.ilim_upper_low == $past(req.wdata[mcc_pkg::ILIM_HI_BIT], 2))
		else $error("upper limit wrong");

	a_ilim_hys: assert property (@(posedge clk) disable iff (!reset_n)
		wr_w |=> ##1 cfg_r.ilim_hys_wide == $past(req.wdata[mcc_pkg::ILIM_HYS_BIT], 2))
		else $error("hysteresis wrong");

	a_olrun_map: assert property (@(posedge clk) disable iff (!reset_n)
		(run_fld_w == 2'h3) |=> cfg_r.ol_run_thresh == mcc_pkg::MCC_OLR_200MA)
		else $error("code 11 must give 200 mA");

	a_olrun_low: assert property (@(posedge clk) disable iff (!reset_n)
		(run_fld_w == mcc_pkg::OL_RUN_100) |=> cfg_r.ol_run_thresh == mcc_pkg::MCC_OLR_100MA)
		else $error("code 01 must give 100 mA");

	a_olrun_high: assert property (@(posedge clk) disable iff (!reset_n)
		(run_fld_w == mcc_pkg::OL_RUN_300) |=> cfg_r.ol_run_thresh == mcc_pkg::MCC_OLR_300MA)
		else $error("code 10 must give 300 mA");

	a_olrun_base: assert property (@(posedge clk) disable iff (!reset_n)
		(run_fld_w == mcc_pkg::OL_RUN_200) |=> cfg_r.ol_run_thresh == mcc_pkg::MCC_OLR_200MA)
		else $error("code 00 must give 200 mA");

	a_slew_alias: assert property (@(posedge clk) disable iff (!reset_n)
		(slew_fld_w == 3'h7) |=> cfg_r.slew_mode == mcc_pkg::MCC_SLEW_OFF)
		else $error("code 111 must be slew off");

	a_slew_off: assert property (@(posedge clk) disable iff (!reset_n)
		(slew_fld_w == 3'h0) |=> cfg_r.slew_mode == mcc_pkg::MCC_SLEW_OFF)
		else $error("code 000 must be slew off");

	a_slew_fastest: assert property (@(posedge clk) disable iff (!reset_n)
		(slew_fld_w == 3'h6) |=> cfg_r.slew_mode == mcc_pkg::MCC_SLEW_FAST1)
		else $error("code 110 must be the fastest rate");

	a_slew_next: assert property (@(posedge clk) disable iff (!reset_n)
		(slew_fld_w == 3'h5) |=> cfg_r.slew_mode == mcc_pkg::MCC_SLEW_FAST2)
		else $error("code 101 must be the next fastest rate");

	a_slew_slow: assert property (@(posedge clk) disable iff (!reset_n)
		(slew_fld_w >= 3'h1 && slew_fld_w <= 3'h4) |=>
		cfg_r.slew_mode == mcc_pkg::mcc_slew_t'($past(slew_fld_w)))
		else $error("slow code gives wrong rate");

	a_oc_mode: assert property (@(posedge clk) disable iff (!reset_n)
		wr_w |=> ##1 cfg_r.oc_auto_recover == $past(req.wdata[mcc_pkg::OC_MODE_BIT], 2))
		else $error("over-current mode wrong");

	a_idle_time: assert property (@(posedge clk) disable iff (!reset_n)
		(idle_fld_w == mcc_pkg::OL_IDLE_500) |=>
		cfg_r.ol_idle_cycles == 17'(mcc_pkg::OL_IDLE_500_CYC))
		else $error("500 us count wrong");

	a_idle_short: assert property (@(posedge clk) disable iff (!reset_n)
		(idle_fld_w == mcc_pkg::OL_IDLE_50) |=>
		cfg_r.ol_idle_cycles == 17'(mcc_pkg::OL_IDLE_50_CYC))
		else $error("50 us count wrong");

	// Undefined code falls back to the reset time so the detector never stalls
	a_idle_default: assert property (@(posedge clk) disable iff (!reset_n)
		(idle_fld_w == mcc_pkg::OL_IDLE_100 || idle_fld_w == mcc_pkg::OL_IDLE_UND) |=>
		cfg_r.ol_idle_cycles == 17'(mcc_pkg::OL_IDLE_100_CYC))
		else $error("100 us count wrong");

	a_idle_flag: assert property (@(posedge clk) disable iff (!reset_n)
		1'b1 |=> cfg_r.ol_idle_valid == ($past(idle_fld_w) != mcc_pkg::OL_IDLE_UND))
		else $error("idle code valid flag wrong");

	a_reg_holds: assert property (@(posedge clk) disable iff (!reset_n)
		!wr_w |=> $stable(cfg_reg_r))
		else $error("register changed without a write");

	a_foreign_write: assert property (@(posedge clk) disable iff (!reset_n)
		(req.wr && !hit_w) |=> $stable(cfg_reg_r))
		else $error("write to other address took effect");

	a_read_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		!req.rd |=> !rvalid_r && rdata_r == 32'h0000_0000)
		else $error("read answer without a read");

	a_read_valid: assert property (@(posedge clk) disable iff (!reset_n)
		req.rd |=> rvalid_r)
		else $error("read not answered");

	a_rdata_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
		rvalid_r |-> (rdata_r & ~mcc_pkg::CH2_CFG_WMASK) == 32'h0000_0000)
		else $error("reserved bits read nonzero");

	// Reset checks carry no disable so they see the first edge after release
	a_reset_reg: assert property (@(posedge clk)
		$rose(reset_n) |-> cfg_reg_r == mcc_pkg::CH2_CFG_RESET)
		else $error("register not at reset value");

	a_reset_idle: assert property (@(posedge clk)
		$rose(reset_n) |-> cfg_r.ol_idle_cycles == 17'(mcc_pkg::OL_IDLE_100_CYC))
		else $error("idle time not at reset value");

	a_reset_side: assert property (@(posedge clk)
		$rose(reset_n) |-> !cfg_r.regen_high_side)
		else $error("regeneration side not at reset value");

	a_reset_limit: assert property (@(posedge clk)
		$rose(reset_n) |-> !cfg_r.ilim_upper_low)
		else $error("upper limit not at reset value");

	a_reset_hyst: assert property (@(posedge clk)
		$rose(reset_n) |-> !cfg_r.ilim_hys_wide)
		else $error("hysteresis not at reset value");

	a_reset_olrun: assert property (@(posedge clk)
		$rose(reset_n) |-> cfg_r.ol_run_thresh == mcc_pkg::MCC_OLR_200MA)
		else $error("running threshold not at reset value");

	a_reset_slew: assert property (@(posedge clk)
		$rose(reset_n) |-> cfg_r.slew_mode == mcc_pkg::MCC_SLEW_OFF)
		else $error("slew mode not at reset value");

	a_reset_latch: assert property (@(posedge clk)
		$rose(reset_n) |-> !cfg_r.oc_auto_recover)
		else $error("over-current mode not at reset value");

	a_reset_read: assert property (@(posedge clk)
		$rose(reset_n) |-> !rvalid_r && rdata_r == 32'h0000_0000)
		else $error("read port not idle after reset");

	a_read_back: assert property (@(posedge clk) disable iff (!reset_n)
		(rd_w && !$past(wr_w)) |=> rdata_r == $past(cfg_reg_r))
		else $error("read data wrong");

	c_write: cover property (@(posedge clk) disable iff (!reset_n) wr_w);
	c_read: cover property (@(posedge clk) disable iff (!reset_n) rd_w);
	c_fast1: cover property (@(posedge clk) disable iff (!reset_n)
		cfg_r.slew_mode == mcc_pkg::MCC_SLEW_FAST1);
	c_undef: cover property (@(posedge clk) disable iff (!reset_n) !cfg_r.ol_idle_valid);

endmodule

/* verification/mcc_host_model.sv */
// Host model that issues register accesses on the strobe port
`timescale 1ns/10ps
module mcc_host_model
(
	// Clock
	input  wire logic        clk,
	// Register port towards the bank
	output mcc_pkg::mcc_req_t req
);
	// ==========================================================
	// Access tasks
	initial req = '0;
	// Strobe lasts one cycle; released fields read zero
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rd(input logic [6:0] a);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk);
		req <= '0;
	endtask
endmodule

/* verification/tb_mcc_cfg_bank.sv */
// Testbench for the channel two configuration bank
`timescale 1ns/10ps
module tb_mcc_cfg_bank;
	logic              clk;
	logic              reset_n;
	mcc_pkg::mcc_req_t req;
	logic [31:0]       rdata_r;
	logic              rvalid_r;
	mcc_pkg::mcc_cfg_t cfg_r;
	int                bad_count;
	int                tests_run;
	int                cyc;
	logic [31:0]       d;
	// ==========================================================
	// Clock, host and design
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	mcc_host_model host_u (.clk(clk), .req(req));
	mcc_cfg_bank dut_u (.clk(clk), .reset_n(reset_n), .req(req), .rdata_r(rdata_r),
		.rvalid_r(rvalid_r), .cfg_r(cfg_r));
	// ==========================================================
	// Expected settings, built apart from the design
	function automatic mcc_pkg::mcc_cfg_t exp_cfg(input logic [31:0] v);
		mcc_pkg::mcc_cfg_t e;
		e.ol_idle_code = v[22:21];
		e.ol_idle_cycles = (v[22:21] == 2'h1) ? 17'd6250 : (v[22:21] == 2'h2) ? 17'd62500 : 17'd12500;
		e.ol_idle_valid = (v[22:21] != 2'h3);
		e.regen_high_side = v[20];
		e.ilim_upper_low = v[18];
		e.ilim_hys_wide = v[17];
		e.ol_run_thresh = (v[16:15] == 2'h1) ? mcc_pkg::MCC_OLR_100MA :
			(v[16:15] == 2'h2) ? mcc_pkg::MCC_OLR_300MA : mcc_pkg::MCC_OLR_200MA;
		e.slew_mode = (v[14:12] == 3'h7) ? mcc_pkg::MCC_SLEW_OFF : mcc_pkg::mcc_slew_t'(v[14:12]);
		e.oc_auto_recover = v[11];
		return e;
	endfunction
	// ==========================================================
	// Compare tasks and closing
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_cfg(input logic [31:0] v);
		mcc_pkg::mcc_cfg_t e;
		e = exp_cfg(v);
		chk({3'h0, cfg_r}, {3'h0, e});
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] e);
		host_u.rd(a);
		// Read answer stands for one cycle only, right after the strobe edge
		#1;
		chk({31'h0, rvalid_r}, 32'h0000_0001);
		chk(rdata_r, e);
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Ceiling well above the hundred or so cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			conclude();
		end
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		reset_n = 1'b0;
		bad_count = 0;
		tests_run = 0;
		cyc = 0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		chk_cfg(32'h0000_0000);
		rd_chk(7'h05, 32'h0000_0000);
		// Every code of each field, reserved bits written as ones
		for (int i = 0; i < 8; i++)
		begin
			d = {6'h3f, 3'h7, i[1:0], i[0], 1'b1, i[1], i[2], i[1:0], i[2:0], i[0], 3'h7, 8'hff};
			host_u.wr(7'h05, d);
			@(posedge clk);
			#1;
			chk_cfg(d);
			rd_chk(7'h05, d & 32'h0077_f800);
			host_u.wr(7'h06, ~d);
			rd_chk(7'h06, 32'h0000_0000);
			#1;
			chk_cfg(d);
		end
		// Reset in mid-run returns every field to its reset value
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		#1;
		chk_cfg(32'h0000_0000);
		@(posedge clk);
		reset_n <= 1'b1;
		rd_chk(7'h05, 32'h0000_0000);
		conclude();
	end
endmodule
